// ===== hdl/lssl_port.v
/*
 Serial load port of a sixteen channel LED sink driver: 17-bit common
 shift register, channel on/off latch, control data latch, status reload
 and output inhibit. Assumes shift_clock, serial_in_line, transfer_strobe
 and output_inhibit arrive asynchronously from an external controller,
 and that status_sources comes from logic on clk_sys.
*/
// How it works
// - While output_inhibit is high every sink channel is held off.
// - While output_inhibit is low each channel follows its on/off latch bit.
// - A transfer_strobe rising edge with the MSB zero copies the shift register into the on/off latch.
// - The same strobe edge reloads the shift register with the selected status word.
// - Each shift_clock rising edge that does not meet a strobe edge in the same cycle captures serial_in_line into the LSB, high meaning one.
// - Each shift_clock rising edge that does not meet a strobe edge in the same cycle moves every shift register bit one place up.
// - serial_out_line is always driven from the shift register MSB.
// - serial_out_line changes only because of a shift_clock rising edge (or strobe reload).
// - At a strobe edge the MSB steers the low 16 bits to on/off latch (0) or control latch (1).
// - The status word is loaded only on a strobe edge while the MSB is zero.
// - After reset all seventeen shift register bits are zero.
// - After reset the on/off latch is zero so all channels start off.
`timescale 1ns/10ps
`include "lssl_defines.vh"

module lssl_port #(
   parameter SR_W = `LSSL_SR_W,
   parameter CH_W = `LSSL_CH_W,
   parameter SEL_W = `LSSL_SEL_W,
   parameter SEL_N = `LSSL_SEL_N,
   parameter DEPTH = `LSSL_FIFO_DEPTH,
   parameter AW = `LSSL_FIFO_AW
) (
   input wire clk_sys,
   input wire srst,
   input wire shift_clock,
   input wire serial_in_line,
   input wire transfer_strobe,
   input wire output_inhibit,
   input wire [SEL_N*CH_W-1:0] status_sources,
   input wire apply_hold,
   output wire serial_out_line,
   output reg [CH_W-1:0] sink_channel_n,
   output reg [CH_W-1:0] control_latch,
   output wire [SEL_W-1:0] status_select_field,
   output wire frame_pending,
   output wire queue_full,
   output reg strobe_lost
);
   // Synchroniser stages
   reg sclk_s1;
   reg sclk_s2;
   reg sclk_d;
   reg sdi_s1;
   reg sdi_s2;
   reg stb_s1;
   reg stb_s2;
   reg stb_d;
   reg inh_s1;
   reg inh_s2;

   reg [SR_W-1:0] shift_reg;
   reg [CH_W-1:0] onoff_latch;
   reg [1:0] state;
   reg [1:0] next_state;
   reg [SR_W-1:0] held_frame;

   wire shift_edge;
   wire strobe_edge;
   wire q_in_valid;
   wire q_in_ready;
   wire q_out_valid;
   wire q_out_ready;
   wire [SR_W-1:0] q_in_data;
   wire [SR_W-1:0] q_out_data;
   wire q_empty;
   wire [CH_W-1:0] status_info_word;

   // Rising edge of a synchronised level
   function rise;
      input prev;
      input cur;
      begin
         rise = cur && !prev;
      end
   endfunction

   // Pick one status word out of the packed sources
   function [CH_W-1:0] pick_status;
      input [SEL_N*CH_W-1:0] src;
      input [SEL_W-1:0] sel;
      integer i;
      begin
         pick_status = {CH_W{1'b0}};
         for (i = 0; i < SEL_N; i = i + 1) begin
            if (sel == i[SEL_W-1:0])
               pick_status = src[i*CH_W +: CH_W];
         end
      end
   endfunction

   always @(posedge clk_sys) begin
      if (srst) begin
         sclk_s1 <= 1'b0;
         sclk_s2 <= 1'b0;
         sclk_d <= 1'b0;
         sdi_s1 <= 1'b0;
         sdi_s2 <= 1'b0;
         stb_s1 <= 1'b0;
         stb_s2 <= 1'b0;
         stb_d <= 1'b0;
         inh_s1 <= 1'b1;
         inh_s2 <= 1'b1;
      end else begin
         sclk_s1 <= shift_clock;
         sclk_s2 <= sclk_s1;
         sclk_d <= sclk_s2;
         sdi_s1 <= serial_in_line;
         sdi_s2 <= sdi_s1;
         stb_s1 <= transfer_strobe;
         stb_s2 <= stb_s1;
         stb_d <= stb_s2;
         inh_s1 <= output_inhibit;
         inh_s2 <= inh_s1;
      end
   end

   assign shift_edge = rise(sclk_d, sclk_s2);
   assign strobe_edge = rise(stb_d, stb_s2);

   assign status_select_field = control_latch[`LSSL_SEL_LSB +: SEL_W];
   assign status_info_word = pick_status(status_sources, status_select_field);

   // Shift register
   always @(posedge clk_sys) begin
      if (srst) begin
         shift_reg <= `LSSL_SR_RST;
      end else if (strobe_edge) begin
         // status reload only when MSB is zero
         if (!shift_reg[`LSSL_SR_MSB]) begin
            shift_reg <= {1'b0, status_info_word};
         end
      end else if (shift_edge) begin
         shift_reg <= {shift_reg[SR_W-2:0], sdi_s2};
      end
   end

   assign serial_out_line = shift_reg[`LSSL_SR_MSB];

   // Commit path: frame captured at strobe edge, queued toward the latches
   localparam ST_IDLE = `LSSL_ST_IDLE;
   localparam ST_WAIT = `LSSL_ST_WAIT;

   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (strobe_edge && !q_in_ready)
               next_state = ST_WAIT;
         end
         ST_WAIT: begin
            // New strobe as the held frame leaves: stay and hold the new one
            if (q_in_ready && !strobe_edge)
               next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always @(posedge clk_sys) begin
      if (srst) begin
         state <= ST_IDLE;
         held_frame <= `LSSL_SR_RST;
         strobe_lost <= 1'b0;
      end else begin
         state <= next_state;
         if (state == ST_IDLE && strobe_edge && !q_in_ready)
            held_frame <= shift_reg;
         if (state == ST_WAIT && strobe_edge && q_in_ready)
            held_frame <= shift_reg;
         // Sticky until reset: a strobe while a frame is already held and the queue is still full
         if (state == ST_WAIT && strobe_edge && !q_in_ready)
            strobe_lost <= 1'b1;
      end
   end

   // frame at strobe edge goes toward the latches
   assign q_in_valid = (state == ST_IDLE) ? strobe_edge : 1'b1;
   assign q_in_data = (state == ST_IDLE) ? shift_reg : held_frame;
   assign frame_pending = (state == ST_WAIT) || !q_empty;
   assign q_out_ready = !apply_hold;

   lssl_fifo #(
      .WIDTH(SR_W),
      .DEPTH(DEPTH),
      .AW(AW)
   ) u_queue (
      .clk_sys(clk_sys),
      .srst(srst),
      .in_valid(q_in_valid),
      .in_ready(q_in_ready),
      .in_data(q_in_data),
      .out_valid(q_out_valid),
      .out_ready(q_out_ready),
      .out_data(q_out_data),
      .full(queue_full),
      .empty(q_empty)
   );

   // Latches
   always @(posedge clk_sys) begin
      if (srst) begin
         onoff_latch <= `LSSL_CH_RST;
         control_latch <= `LSSL_CTRL_RST;
      end else if (q_out_valid && q_out_ready) begin
         if (q_out_data[`LSSL_SR_MSB])
            control_latch <= q_out_data[CH_W-1:0];
         else
            onoff_latch <= q_out_data[CH_W-1:0];
      end
   end

   // Sink drive
   always @(posedge clk_sys) begin
      if (srst) begin
         sink_channel_n <= `LSSL_CH_RST;
      end else if (inh_s2) begin
         sink_channel_n <= `LSSL_CH_RST;
      end else begin
         sink_channel_n <= onoff_latch;
      end
   end
endmodule // lssl_port

// ===== pkg/lssl_defines.vh
/*
 Constants for the LED sink serial load port: widths, reset values,
 field positions and queue depth. Assumes inclusion by bare name.
*/
`ifndef LSSL_DEFINES_VH
`define LSSL_DEFINES_VH

// Common shift register and latch widths
`define LSSL_SR_W 17
`define LSSL_SR_MSB 16
`define LSSL_CH_W 16
`define LSSL_CH_MSB 15

// Power-up values
`define LSSL_SR_RST 17'h00000
`define LSSL_CH_RST 16'h0000
`define LSSL_CTRL_RST 16'h0000

// Status select field inside the control data latch
`define LSSL_SEL_LSB 0
`define LSSL_SEL_W 2
`define LSSL_SEL_N 4

// Frame queue between strobe and latches
`define LSSL_FIFO_DEPTH 8
`define LSSL_FIFO_AW 3

// Commit state codes, one-hot
`define LSSL_ST_IDLE 2'h1
`define LSSL_ST_WAIT 2'h2

`endif

// ===== hdl/lssl_fifo.v
/*
 Synchronous FIFO with valid/ready on both sides and honest full/empty.
 Assumes one clock, synchronous active-high reset.
*/
`timescale 1ns/10ps
`include "lssl_defines.vh"

module lssl_fifo #(
   parameter WIDTH = `LSSL_SR_W,
   parameter DEPTH = `LSSL_FIFO_DEPTH,
   parameter AW = `LSSL_FIFO_AW
) (
   input wire clk_sys,
   input wire srst,
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data,
   output wire full,
   output wire empty
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr;
   reg [AW-1:0] rd_ptr;
   reg [AW:0] count;
   wire push;
   wire pop;

   assign full = (count == DEPTH[AW:0]);
   assign empty = (count == {(AW+1){1'b0}});
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem[rd_ptr];
   assign push = in_valid && !full;
   assign pop = out_ready && !empty;

   // Pointer wrap for non power-of-two depths
   function [AW-1:0] bump;
      input [AW-1:0] p;
      begin
         if (p == DEPTH[AW-1:0] - 1'b1 || DEPTH == (1 << AW) && p == {AW{1'b1}})
            bump = {AW{1'b0}};
         else
            bump = p + 1'b1;
      end
   endfunction

   always @(posedge clk_sys) begin
      if (push)
         mem[wr_ptr] <= in_data;
   end

   always @(posedge clk_sys) begin
      if (srst) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end else begin
         if (push)
            wr_ptr <= bump(wr_ptr);
         if (pop)
            rd_ptr <= bump(rd_ptr);
         if (push && !pop)
            count <= count + 1'b1;
         else if (pop && !push)
            count <= count - 1'b1;
      end
   end
endmodule // lssl_fifo

// ===== verification/lssl_ctl.sv
/*
 Controller model: shifts frames in and strobes them.
 Assumes the port samples these pins on its own clock.
*/
`timescale 1ns/10ps
module lssl_ctl (
   output reg shift_clock,
   output reg serial_in_line,
   output reg transfer_strobe,
   input wire serial_out_line
);
   reg [16:0] rx = 0;
   integer k;
   initial begin
      shift_clock = 0;
      serial_in_line = 0;
      transfer_strobe = 0;
   end
   task send(input [16:0] f);
      for (k = 16; k >= 0; k = k - 1) begin
         serial_in_line <= f[k];
         #62.5 rx = {rx[15:0], serial_out_line};
         shift_clock <= 1'b1;
         #62.5 shift_clock <= 1'b0;
      end
   endtask
   task strobe;
      begin
         transfer_strobe <= 1'b1;
         #62.5 transfer_strobe <= 1'b0;
         #62.5;
      end
   endtask
endmodule // lssl_ctl

// ===== verification/lssl_port_asserts.sv
/*
 Checker bound to lssl_port.
 Assumes the port's clock and synchronous reset.
*/
`timescale 1ns/10ps
module lssl_port_chk #(
   parameter CH_W = 16,
   parameter SEL_W = 2,
   parameter SEL_N = 4
) (
   input wire clk_sys,
   input wire srst,
   input wire shift_clock,
   input wire serial_in_line,
   input wire transfer_strobe,
   input wire output_inhibit,
   input wire [SEL_N*CH_W-1:0] status_sources,
   input wire apply_hold,
   input wire serial_out_line,
   input wire [CH_W-1:0] sink_channel_n,
   input wire [CH_W-1:0] control_latch,
   input wire [SEL_W-1:0] status_select_field,
   input wire frame_pending,
   input wire queue_full,
   input wire strobe_lost
);
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (srst);
   a_inhibit_off: assert property (output_inhibit [*4] |-> sink_channel_n == 0)
      else $error("sinks on while inhibited");
   a_sinks_hold: assert property (
      (!transfer_strobe && !apply_hold && !frame_pending && $stable(output_inhibit)) [*6]
      |-> $stable(sink_channel_n)) else $error("sinks moved without cause");
   a_ctrl_hold: assert property (
      (!transfer_strobe && !frame_pending) [*6] |-> $stable(control_latch))
      else $error("control latch moved without strobe");
   a_tail_quiet: assert property ((!shift_clock) [*5] |-> $stable(serial_out_line))
      else $error("serial out moved without shift");
   a_tail_cause: assert property ($changed(serial_out_line) |-> $past(shift_clock))
      else $error("serial out moved outside shift");
   a_reset_clear: assert property ($past(srst) |->
      !serial_out_line && sink_channel_n == 0 && control_latch == 0)
      else $error("state not clear after reset");
   a_sel_mirror: assert property (status_select_field == control_latch[SEL_W-1:0])
      else $error("select field differs from control latch");
   a_full_pending: assert property (queue_full |-> frame_pending)
      else $error("full queue without pending frame");
   c_full: cover property (queue_full);
   c_ctrl: cover property ($changed(control_latch));
   c_sinks: cover property ($changed(sink_channel_n));
endmodule // lssl_port_chk
bind lssl_port lssl_port_chk #(.CH_W(CH_W), .SEL_W(SEL_W), .SEL_N(SEL_N)) i_lssl_port_chk (.*);

// ===== verification/tb.sv
/*
 Bench: random frames, inhibit, queue fill, model compare.
 Assumes lssl_port, lssl_ctl and the checker are compiled.
*/
`timescale 1ns/10ps
module tb;
   reg clk_sys = 0;
   reg srst = 1;
   reg output_inhibit = 0;
   reg apply_hold = 0;
   reg [63:0] status_sources = 0;
   wire shift_clock, serial_in_line, transfer_strobe, serial_out_line;
   wire frame_pending, queue_full, strobe_lost;
   wire [15:0] sink_channel_n, control_latch;
   wire [1:0] status_select_field;
   integer error_cnt = 0;
   integer n_tests = 0;
   integer i;
   reg [31:0] seed = 32'h466a;
   reg [31:0] r;
   reg [16:0] sr = 0;
   reg [15:0] onoff = 0;
   reg [15:0] ctrl = 0;
   always #5 clk_sys = ~clk_sys;
   lssl_port i_lssl_port (
      .clk_sys(clk_sys),
      .srst(srst),
      .shift_clock(shift_clock),
      .serial_in_line(serial_in_line),
      .transfer_strobe(transfer_strobe),
      .output_inhibit(output_inhibit),
      .status_sources(status_sources),
      .apply_hold(apply_hold),
      .serial_out_line(serial_out_line),
      .sink_channel_n(sink_channel_n),
      .control_latch(control_latch),
      .status_select_field(status_select_field),
      .frame_pending(frame_pending),
      .queue_full(queue_full),
      .strobe_lost(strobe_lost)
   );
   lssl_ctl i_lssl_ctl (
      .shift_clock(shift_clock),
      .serial_in_line(serial_in_line),
      .transfer_strobe(transfer_strobe),
      .serial_out_line(serial_out_line)
   );
   function [31:0] rnd(input x);
      begin
         seed = seed ^ (seed << 13);
         seed = seed ^ (seed >> 17);
         seed = seed ^ (seed << 5);
         rnd = seed;
      end
   endfunction
   task cmp(input [16:0] got, input [16:0] exp);
      begin
         n_tests = n_tests + 1;
         if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   // Shifted-out frame and serial output
   task chk_frame(input [16:0] got, input [16:0] exp);
      cmp(got, exp);
   endtask
   // Sink channel drive
   task chk_sink(input [15:0] got, input [15:0] exp);
      cmp({1'b0, got}, {1'b0, exp});
   endtask
   // Control latch and select field
   task chk_ctrl(input [15:0] got, input [15:0] exp);
      cmp({1'b0, got}, {1'b0, exp});
   endtask
   // Queue and lost-strobe flags
   task chk_flag(input [2:0] got, input [2:0] exp);
      cmp({14'h0000, got}, {14'h0000, exp});
   endtask
   task complete_run;
      begin
         if (error_cnt == 0 && n_tests > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   task commit;
      begin
         i_lssl_ctl.strobe;
         if (sr[16])
            ctrl = sr[15:0];
         else begin
            onoff = sr[15:0];
            sr = {1'b0, status_sources[16*ctrl[1:0] +: 16]};
         end
         if (!apply_hold) begin
            chk_sink(sink_channel_n, output_inhibit ? 16'h0000 : onoff);
            chk_ctrl(control_latch, ctrl);
            chk_ctrl({14'h0000, status_select_field}, {14'h0000, ctrl[1:0]});
         end
      end
   endtask
   task frame(input [16:0] f);
      begin
         i_lssl_ctl.send(f);
         chk_frame(i_lssl_ctl.rx, sr);
         sr = f;
         commit;
      end
   endtask
   initial begin
      #200000;
      error_cnt = error_cnt + 1;
      complete_run;
   end
   initial begin
      repeat (10) @(posedge clk_sys);
      srst <= 0;
      status_sources <= {rnd(0), rnd(0)};
      @(posedge clk_sys);
      chk_frame({16'h0000, serial_out_line}, 17'h00000);
      chk_sink(sink_channel_n, 16'h0000);
      for (i = 0; i < 8; i = i + 1) begin
         r = rnd(0);
         frame({1'b1, r[15:2], i[1:0]});
         frame({1'b0, r[31:16]});
      end
      @(posedge clk_sys);
      output_inhibit <= 1'b1;
      frame(17'h0ffff);
      chk_sink(sink_channel_n, 16'h0000);
      @(posedge clk_sys);
      output_inhibit <= 1'b0;
      repeat (5) @(posedge clk_sys);
      chk_sink(sink_channel_n, onoff);
      @(posedge clk_sys);
      apply_hold <= 1'b1;
      for (i = 0; i < 8; i = i + 1)
         commit;
      chk_flag({strobe_lost, queue_full, frame_pending}, 3'h3);
      // One frame held beside the full queue, the next one lost
      commit;
      commit;
      chk_flag({strobe_lost, queue_full, frame_pending}, 3'h7);
      @(posedge clk_sys);
      apply_hold <= 1'b0;
      repeat (20) @(posedge clk_sys);
      chk_flag({strobe_lost, queue_full, frame_pending}, 3'h4);
      chk_sink(sink_channel_n, onoff);
      // Mid-run reset clears register, latches and flags
      srst <= 1'b1;
      repeat (3) @(posedge clk_sys);
      srst <= 1'b0;
      sr = 17'h00000;
      onoff = 16'h0000;
      ctrl = 16'h0000;
      @(posedge clk_sys);
      chk_frame({16'h0000, serial_out_line}, 17'h00000);
      chk_sink(sink_channel_n, 16'h0000);
      chk_ctrl(control_latch, 16'h0000);
      chk_flag({strobe_lost, queue_full, frame_pending}, 3'h0);
      r = rnd(0);
      frame({1'b0, r[15:0]});
      complete_run;
   end
endmodule // tb
